//--- logic/cmp_bank_params.svh
// Register offsets, field positions and reset values of the comparator bank
`ifndef CMP_BANK_PARAMS_SVH
`define CMP_BANK_PARAMS_SVH
`define CMP_NUM_CH 5
`define CMP_ADDR_IRQ_EN 8'h84
`define CMP_ADDR_IRQ_FLG 8'h85
`define CMP_ADDR_CTRL_BASE 8'hC1
`define CMP_ADDR_CAL_BASE 8'hE9
`define CMP_ADDR_EDGE 8'hD7
`define CMP_BIT_EN 7
`define CMP_BIT_HYS 6
`define CMP_BIT_RESULT 7
`define CMP_BIT_MODE 6
`define CMP_BIT_CTS 5
`define CMP_VRF_W 6
`define CMP_SYNC_W 5
`define CMP_TRIM_W 5
`define CMP_CTRL_RESET 8'h00
`define CMP_CAL_RESET 8'h00
`define CMP_TRIM_RESET 5'h10
`define CMP_PWM_FLAG_RESET 2'h0
`endif

//--- logic/cmp_bank_pkg.sv
// Types shared by the comparator bank
package cmp_bank_pkg;
  typedef logic [7:0] sfr_byte_t;
  typedef logic [4:0] ch_vec_t;
endpackage : cmp_bank_pkg

//--- logic/comparator_bank_control.sv
// Digital control and interrupt flags for five analog comparators
// Contract
// [RULE1] Result is high when plus input exceeds minus input, else low.
// [RULE2] Five channels, each with control, calibration and edge-select bit.
// [RULE3] Enable bit turns comparator on; disabled output forced low.
// [RULE4] Per-channel hysteresis enable bit drives analog hysteresis.
// [RULE5] Edge bit one flags on rising result, zero on falling.
// [RULE6] Hardware sets flag on selected edge; flags in bits 4..0.
// [RULE7] Writing zero clears a flag bit; writing one leaves it.
// [RULE8] Interrupt enable register bits 4..0, one per channel.
// [RULE9] Channel request asserted while flag and enable both one.
// [RULE10] Channels two to five use internal reference on plus input.
// [RULE11] Channel one takes both inputs from external pins.
// [RULE12] Current result readable in calibration register status bit.
// [RULE13] Calibration mode ties both inputs to internal cal source.
// [RULE14] Terminal-select bit routes cal source: one plus, zero minus.
// [RULE15] Software sweeps trim up and down, applies value, leaves cal.
// [RULE16] Trim writes accepted only while calibration mode bit set.
// [RULE17] Enabled comparator disables digital input paths of its pins.
// [RULE18] Channel one control: enable b7, hysteresis b6, b5 reserved, sync b4..0.
// [RULE19] Channels two-five reference field six bits, level value/64 of supply.
`include "cmp_bank_params.svh"
module comparator_bank_control (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Special function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  // Raw analog comparator decisions, plus above minus
  input wire logic [4:0] analog_result_in,
  // Analog core controls
  output logic [4:0] channel_enable_bit_out,
  output logic [4:0] hysteresis_enable_bit_out,
  output logic [4:0] calibration_mode_bit_out,
  output logic [4:0] cal_terminal_select_bit_out,
  output logic [24:0] offset_trim_field_out,
  output logic [23:0] reference_select_field_out,
  output logic [4:0] sync_debounce_field_out,
  output logic [4:0] pin_digital_disable_out,
  // Interrupt requests and PWM flag set inputs
  input wire logic [1:0] pwm_flag_set_in,
  output logic [4:0] channel_irq_out
);
  logic rst_s1, rst_n;
  // Reset release through two flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  cmp_bank_pkg::sfr_byte_t ctrl [5];
  cmp_bank_pkg::sfr_byte_t next_ctrl [5];
  logic [1:0] calmode [5];
  logic [1:0] next_calmode [5];
  logic [4:0] trim [5];
  logic [4:0] next_trim [5];
  cmp_bank_pkg::ch_vec_t edge_sel, next_edge_sel, irq_en, next_irq_en;
  cmp_bank_pkg::ch_vec_t flag, next_flag, result, prev_result, evt;
  logic [2:0] irq_en_pwm, next_irq_en_pwm;
  logic [1:0] pwm_flag, next_pwm_flag;
  cmp_bank_pkg::sfr_byte_t next_rdata;

  // Gated results and edge events
  always_comb begin
    result = analog_result_in & channel_enable_bit_out; // [RULE1] [RULE3]
    for (int i = 0; i < `CMP_NUM_CH; i++) begin
      evt[i] = edge_sel[i] ? (result[i] & ~prev_result[i]) : (~result[i] & prev_result[i]); // [RULE5]
    end
  end

  // Next-state of the control, calibration, edge, enable and flag registers
  always_comb begin
    next_edge_sel = edge_sel;
    next_irq_en = irq_en;
    next_irq_en_pwm = irq_en_pwm;
    next_flag = flag | evt; // [RULE6]
    next_pwm_flag = pwm_flag | pwm_flag_set_in;
    for (int i = 0; i < `CMP_NUM_CH; i++) begin
      next_ctrl[i] = ctrl[i];
      next_calmode[i] = calmode[i];
      next_trim[i] = trim[i];
    end
    if (sfr_wr_in) begin
      if (sfr_addr_in == `CMP_ADDR_IRQ_EN) begin
        next_irq_en = sfr_wdata_in[4:0]; // [RULE8]
        next_irq_en_pwm = sfr_wdata_in[7:5];
      end else if (sfr_addr_in == `CMP_ADDR_IRQ_FLG) begin
        // A new edge in the same cycle as a clearing write keeps its flag
        next_flag = (flag & sfr_wdata_in[4:0]) | evt; // [RULE7]
        next_pwm_flag = (pwm_flag & sfr_wdata_in[6:5]) | pwm_flag_set_in;
      end else if (sfr_addr_in == `CMP_ADDR_EDGE) begin
        next_edge_sel = sfr_wdata_in[4:0]; // [RULE5]
      end else begin
        for (int i = 0; i < `CMP_NUM_CH; i++) begin
          if (sfr_addr_in == `CMP_ADDR_CTRL_BASE + 8'(i)) begin
            next_ctrl[i] = (i == 0) ? (sfr_wdata_in & 8'hDF) : sfr_wdata_in; // [RULE18]
          end
          if (sfr_addr_in == `CMP_ADDR_CAL_BASE + 8'(i)) begin
            next_calmode[i] = sfr_wdata_in[6:5];
            if (calmode[i][1] && sfr_wdata_in[`CMP_BIT_MODE]) begin
              next_trim[i] = sfr_wdata_in[4:0]; // [RULE16]
            end
          end
        end
      end
    end
  end

  // Register update
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CMP_NUM_CH; i++) begin
        ctrl[i] <= `CMP_CTRL_RESET;
        calmode[i] <= 2'h0;
        trim[i] <= `CMP_TRIM_RESET;
      end
      edge_sel <= 5'h00;
      irq_en <= 5'h00;
      irq_en_pwm <= 3'h0;
      flag <= 5'h00;
      pwm_flag <= `CMP_PWM_FLAG_RESET;
      prev_result <= 5'h00;
    end else begin
      for (int i = 0; i < `CMP_NUM_CH; i++) begin // [RULE2]
        ctrl[i] <= next_ctrl[i];
        calmode[i] <= next_calmode[i];
        trim[i] <= next_trim[i];
      end
      edge_sel <= next_edge_sel;
      irq_en <= next_irq_en;
      irq_en_pwm <= next_irq_en_pwm;
      flag <= next_flag;
      pwm_flag <= next_pwm_flag;
      prev_result <= result;
    end
  end

  // Analog control outputs
  always_comb begin
    for (int i = 0; i < `CMP_NUM_CH; i++) begin
      channel_enable_bit_out[i] = ctrl[i][`CMP_BIT_EN]; // [RULE3]
      hysteresis_enable_bit_out[i] = ctrl[i][`CMP_BIT_HYS]; // [RULE4]
      calibration_mode_bit_out[i] = calmode[i][1]; // [RULE13]
      cal_terminal_select_bit_out[i] = calmode[i][0]; // [RULE14]
      offset_trim_field_out[i*5 +: 5] = trim[i];
    end
    for (int i = 1; i < `CMP_NUM_CH; i++) begin
      reference_select_field_out[(i-1)*6 +: 6] = ctrl[i][5:0]; // [RULE10] [RULE19]
    end
    sync_debounce_field_out = ctrl[0][4:0]; // [RULE11] [RULE18]
    pin_digital_disable_out = channel_enable_bit_out; // [RULE17]
    channel_irq_out = flag & irq_en; // [RULE9]
  end

  // Read data select, held between reads
  always_comb begin
    next_rdata = sfr_rdata_out;
    if (sfr_rd_in) begin
      next_rdata = 8'h00; // Unmapped reads return zero
      if (sfr_addr_in == `CMP_ADDR_IRQ_EN) begin
        next_rdata = {irq_en_pwm, irq_en};
      end else if (sfr_addr_in == `CMP_ADDR_IRQ_FLG) begin
        next_rdata = {1'b0, pwm_flag, flag};
      end else if (sfr_addr_in == `CMP_ADDR_EDGE) begin
        next_rdata = {3'h0, edge_sel};
      end else begin
        for (int i = 0; i < `CMP_NUM_CH; i++) begin
          if (sfr_addr_in == `CMP_ADDR_CTRL_BASE + 8'(i)) begin
            next_rdata = ctrl[i];
          end
          if (sfr_addr_in == `CMP_ADDR_CAL_BASE + 8'(i)) begin
            next_rdata = {result[i], calmode[i], trim[i]}; // [RULE12]
          end
        end
      end
    end
  end

  // Read data register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_out <= 8'h00;
    end else begin
      sfr_rdata_out <= next_rdata;
    end
  end

  // Checks on results and flags
  AST_DISABLED_LOW: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE3]
    !channel_enable_bit_out[0] |-> ##1 !prev_result[0]) else $error("disabled channel result not low");
  AST_RISE_FLAG: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE5]
    edge_sel[1] && result[1] && !prev_result[1] |=> flag[1]) else $error("rising edge missed");
  AST_FALL_FLAG: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE6]
    !edge_sel[2] && !result[2] && prev_result[2] |=> flag[2]) else $error("falling edge missed");
  AST_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE7]
    sfr_wr_in && sfr_addr_in == `CMP_ADDR_IRQ_FLG && !sfr_wdata_in[0] && !evt[0] |=> !flag[0])
    else $error("flag clear failed");
  AST_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE7]
    sfr_wr_in && sfr_addr_in == `CMP_ADDR_IRQ_FLG && sfr_wdata_in[3] && flag[3] |=> flag[3])
    else $error("flag lost on write one");
  // Enabling a channel with a pending flag raises its request next cycle
  AST_IRQ: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE9]
    sfr_wr_in && sfr_addr_in == `CMP_ADDR_IRQ_EN && sfr_wdata_in[1] && flag[1] |=> channel_irq_out[1])
    else $error("irq not raised");
  // Checks on register writes
  AST_IEN: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE8]
    sfr_wr_in && sfr_addr_in == `CMP_ADDR_IRQ_EN |=> {3'h0, irq_en} == ($past(sfr_wdata_in) & 8'h1F))
    else $error("enable write lost");
  AST_TRIM_LOCK: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE16]
    !calibration_mode_bit_out[0] |=> trim[0] == $past(trim[0])) else $error("trim changed outside cal");
  AST_PIN: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE17]
    sfr_wr_in && sfr_addr_in == `CMP_ADDR_CTRL_BASE |=>
    pin_digital_disable_out[0] == $past(sfr_wdata_in[`CMP_BIT_EN])) else $error("pin disable wrong");
  AST_MODE: assert property (@(posedge clk_in) disable iff (!rst_n) // [RULE13]
    sfr_wr_in && sfr_addr_in == `CMP_ADDR_CAL_BASE |=> calibration_mode_bit_out[0] == $past(sfr_wdata_in[6]))
    else $error("cal mode write lost");
  // Main scenarios
  COV_RISE: cover property (@(posedge clk_in) disable iff (!rst_n) evt[0] && edge_sel[0]);
  COV_FALL: cover property (@(posedge clk_in) disable iff (!rst_n) evt[4] && !edge_sel[4]);
  COV_IRQ: cover property (@(posedge clk_in) disable iff (!rst_n) |channel_irq_out);
  COV_TRIM: cover property (@(posedge clk_in) disable iff (!rst_n) calibration_mode_bit_out[0] ##1 trim[0] != 5'h10);
endmodule : comparator_bank_control

//--- sim/cmp_core_model.sv
// Behavioural model of the five analog comparator cores
module cmp_core_model (
  // Settings from the bank
  input wire logic [4:0] cal_in,
  input wire logic [23:0] ref_in,
  input wire logic [24:0] trim_in,
  // Pin levels, supply taken as 256 steps
  input wire logic [7:0] pin1_plus_in,
  input wire logic [39:0] minus_in,
  // Raw decisions, enable ignored on purpose
  output logic [4:0] result_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [29:0] refx;
  logic [7:0] plus;
  assign refx = {ref_in, 6'h00};
  // Plus from pin or reference; cal offset sits at mid trim
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      plus = (i == 0) ? pin1_plus_in : {refx[6*i+:6], 2'b00};
      result_out[i] = cal_in[i] ? trim_in[5*i+4] : (plus > minus_in[8*i+:8]);
    end
  end
endmodule : cmp_core_model

//--- sim/tb.sv
// Self-checking bench for the comparator bank control
`include "cmp_bank_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, pin1 = 8'h00, d, v, rdat;
  logic [39:0] minus = '1;
  logic [4:0] res, en, hys, cal, cts, sync, pdis, irq, e;
  logic [24:0] trim;
  logic [23:0] refs;
  int err_total = 0, n_tests = 0;
  int hi = -1, lo = -1;
  logic [1:0] pwm = 2'h0;
  comparator_bank_control dut (.clk_in(clk), .rst_n_in(rst_n), .sfr_addr_in(addr),
    .sfr_wdata_in(wdat), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdat),
    .analog_result_in(res), .channel_enable_bit_out(en), .hysteresis_enable_bit_out(hys),
    .calibration_mode_bit_out(cal), .cal_terminal_select_bit_out(cts), .offset_trim_field_out(trim),
    .reference_select_field_out(refs), .sync_debounce_field_out(sync),
    .pin_digital_disable_out(pdis), .pwm_flag_set_in(pwm), .channel_irq_out(irq));
  cmp_core_model core (.cal_in(cal), .ref_in(refs), .trim_in(trim), .pin1_plus_in(pin1),
    .minus_in(minus), .result_out(res));
  // Clock
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask : chk
  // Expected control readback: channel one bit 5 is reserved
  function automatic logic [7:0] ctrl_exp(input int ch, input logic [7:0] val);
    return (ch == 0) ? (val & 8'hDF) : val;
  endfunction : ctrl_exp
  // Expected decision: high only when plus is strictly above minus
  function automatic logic cmp_exp(input logic [7:0] plus_lvl, input logic [7:0] minus_lvl);
    return plus_lvl > minus_lvl;
  endfunction : cmp_exp
  task automatic wrr(input logic [7:0] a, dv);
    @(negedge clk);
    addr = a;
    wdat = dv;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask : wrr
  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdat;
  endtask : rdr
  task automatic test_done();
    $display("mismatches %0d of %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    #200000;
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    void'($urandom(32'hDF23));
    repeat (16) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    // Reset values and an unmapped address
    rdr(`CMP_ADDR_IRQ_EN);
    chk(d, 8'h00);
    rdr(`CMP_ADDR_IRQ_FLG);
    chk(d, 8'h00);
    rdr(`CMP_ADDR_CAL_BASE);
    chk(d, 8'h10);
    rdr(8'h00);
    chk(d, 8'h00);
    // Random control bytes on every channel
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      wrr(`CMP_ADDR_CTRL_BASE + 8'(i), v);
      rdr(`CMP_ADDR_CTRL_BASE + 8'(i));
      chk(d, ctrl_exp(i, v));
      chk({en[i], pdis[i]}, {v[7], v[7]});
      chk(hys[i], v[6]);
      if (i == 0) chk(sync, v[4:0]);
      else chk(refs[6*(i-1)+:6], v[5:0]);
    end
    // All on, plus level at 80h
    pin1 = 8'h80;
    for (int i = 0; i < 5; i++) wrr(`CMP_ADDR_CTRL_BASE + 8'(i), i == 0 ? 8'h80 : 8'hA0);
    for (int k = 0; k < 3; k++) begin
      e = k == 0 ? 5'h1F : k == 1 ? 5'h00 : 5'($urandom);
      minus = '1;
      wrr(`CMP_ADDR_IRQ_EN, 8'h1F);
      wrr(`CMP_ADDR_EDGE, {3'h0, e});
      wrr(`CMP_ADDR_IRQ_FLG, 8'h00);
      minus = '0;
      repeat (4) @(negedge clk);
      rdr(`CMP_ADDR_IRQ_FLG);
      chk(d, {3'h0, e});
      chk(irq, e);
      minus = '1;
      repeat (4) @(negedge clk);
      rdr(`CMP_ADDR_IRQ_FLG);
      chk(d, 8'h1F);
      wrr(`CMP_ADDR_IRQ_FLG, 8'hFE);
      rdr(`CMP_ADDR_IRQ_FLG);
      chk(d, 8'h1E);
      wrr(`CMP_ADDR_IRQ_EN, 8'h00);
      chk(irq, 5'h00);
    end
    // Neighbouring flag bits set and cleared without touching comparator flags
    pwm = 2'h3;
    @(negedge clk);
    pwm = 2'h0;
    rdr(`CMP_ADDR_IRQ_FLG);
    chk(d, 8'h7E);
    wrr(`CMP_ADDR_IRQ_FLG, 8'h9F);
    rdr(`CMP_ADDR_IRQ_FLG);
    chk(d, 8'h1E);
    minus = {8'($urandom), 32'($urandom)};
    for (int i = 0; i < 5; i++) begin
      rdr(`CMP_ADDR_CAL_BASE + 8'(i));
      chk(d[7], cmp_exp(8'h80, minus[8*i+:8]));
    end
    minus = '0;
    for (int i = 0; i < 5; i++) begin
      wrr(`CMP_ADDR_CTRL_BASE + 8'(i), 8'h00);
      rdr(`CMP_ADDR_CAL_BASE + 8'(i));
      chk(d[7], 1'b0);
    end
    // Calibration on channel one
    wrr(`CMP_ADDR_CTRL_BASE, 8'h80);
    wrr(`CMP_ADDR_CAL_BASE, 8'h05);
    chk(trim[4:0], 5'h10);
    wrr(`CMP_ADDR_CAL_BASE, 8'h40);
    wrr(`CMP_ADDR_CAL_BASE, 8'h65);
    chk({cal[0], cts[0], trim[4:0]}, 7'h65);
    rdr(`CMP_ADDR_CAL_BASE);
    chk(d, 8'h65);
    wrr(`CMP_ADDR_CAL_BASE, 8'h5F);
    rdr(`CMP_ADDR_CAL_BASE);
    chk(d, 8'hDF);
    wrr(`CMP_ADDR_CAL_BASE, 8'h00);
    chk(trim[4:0], 5'h1F);
    // Trim sweep up then down; the model flips at mid trim
    wrr(`CMP_ADDR_CAL_BASE, 8'h40);
    for (int t = 0; t < 32; t++) begin
      wrr(`CMP_ADDR_CAL_BASE, 8'h40 | 8'(t));
      rdr(`CMP_ADDR_CAL_BASE);
      if (d[7] && hi < 0) hi = t;
    end
    for (int t = 31; t >= 0; t--) begin
      wrr(`CMP_ADDR_CAL_BASE, 8'h40 | 8'(t));
      rdr(`CMP_ADDR_CAL_BASE);
      if (!d[7] && lo < 0) lo = t;
    end
    chk(hi, 16);
    chk(lo, 15);
    // Apply the average, then leave calibration mode
    wrr(`CMP_ADDR_CAL_BASE, 8'h40 | 8'((hi + lo) / 2));
    wrr(`CMP_ADDR_CAL_BASE, 8'h00);
    chk(trim[4:0], 5'h0F);
    test_done();
  end
endmodule : tb
